// file: audio_pkg.sv
// Shared constants, types and companding functions for the audio port
package audio_pkg;

	// Device register offsets
	localparam logic [7:0] OFS_COMPAND = 8'h18;
	localparam logic [7:0] OFS_DIR = 8'h19;
	localparam logic [7:0] OFS_BDIV = 8'h1a;
	localparam logic [7:0] OFS_FRATE = 8'h1b;

	// Field positions in the device registers
	localparam int TX_EN_BIT = 3;
	localparam int TX_TYPE_BIT = 2;
	localparam int RX_EN_BIT = 1;
	localparam int RX_TYPE_BIT = 0;
	localparam int FRAME_DIR_BIT = 9;
	localparam int BIT_DIR_BIT = 6;

	// Reset values and limits
	localparam logic [4:0] BDIV_RESET = 5'h08;
	localparam logic [5:0] BDIV_MIN = 6'h02;
	localparam logic [5:0] BDIV_DEFAULT = 6'h08;
	localparam logic [10:0] FRATE_RESET = 11'h022;
	localparam logic [10:0] FRATE_MIN = 11'h008;
	localparam logic [2:0] WORD_LAST = 3'h7;

	// Companding constants
	localparam logic [13:0] MU_CLIP = 14'h1fde;
	localparam logic [13:0] MU_BIAS = 14'h0021;
	localparam logic [7:0] MU_INV = 8'hff;
	localparam logic [7:0] A_INV = 8'h55;
	localparam logic [3:0] MU_BASE = 4'h5;
	localparam logic [3:0] A_BASE = 4'h4;

	// Controller register offsets and fields
	localparam logic [11:0] H_CTRL = 12'h000;
	localparam logic [11:0] H_HALF = 12'h004;
	localparam logic [11:0] H_RATE = 12'h008;
	localparam logic [11:0] H_TX = 12'h00c;
	localparam logic [11:0] H_RX = 12'h010;
	localparam int H_DRV_BCLK = 0;
	localparam int H_DRV_FRAME = 1;
	localparam int H_MODE_B = 2;
	localparam int H_RUN = 3;
	localparam logic [7:0] H_HALF_RESET = 8'h04;

	typedef enum logic [1:0] {
		WORD_IDLE = 2'b00,
		WORD_ARMED = 2'b01,
		WORD_SHIFT = 2'b10
	} word_state_t;

	// Bit clock divider code to ratio; reserved codes fall back to 8
	function automatic logic [5:0] div_ratio(input logic [4:0] code);
		case (code)
			5'h00: return 6'h01;
			5'h02: return 6'h02;
			5'h03: return 6'h03;
			5'h04: return 6'h04;
			5'h05: return 6'h05;
			5'h07: return 6'h06;
			5'h09: return 6'h0a;
			5'h0b: return 6'h0c;
			5'h0c: return 6'h10;
			5'h0d: return 6'h14;
			5'h0e: return 6'h16;
			5'h0f: return 6'h18;
			5'h11: return 6'h1e;
			5'h12: return 6'h20;
			5'h13: return 6'h2c;
			5'h14: return 6'h30;
			default: return BDIV_DEFAULT;
		endcase
	endfunction

	// Segment number from the leading one of a magnitude
	function automatic logic [2:0] seg_of(input logic [12:0] m,
		input logic [3:0] base);
		logic [3:0] e;
		e = 4'h0;
		for (int i = 5; i < 13; i++) begin
			if (m[i]) begin
				e = 4'(i) - base;
			end
		end
		return e[2:0];
	endfunction

	// Linear 16-bit sample to companded byte, inversion applied
	function automatic logic [7:0] compress(input logic [15:0] s,
		input logic alaw);
		logic neg;
		logic [13:0] mag;
		logic [12:0] m;
		logic [2:0] e;
		logic [3:0] t;
		neg = s[15];
		mag = 14'h0000;
		m = 13'h0000;
		e = 3'h0;
		t = 4'h0;
		if (!alaw) begin
			mag = neg ? 14'(-s[15:2]) : s[15:2];
			if (mag > MU_CLIP) begin
				mag = MU_CLIP;
			end
			m = 13'(mag + MU_BIAS);
			e = seg_of(m, MU_BASE);
			// Widened first: segment seven needs a shift of eight
			t = 4'(m >> (4'(e) + 4'h1));
			return {neg, e, t} ^ MU_INV;
		end
		m = neg ? {1'b0, ~s[14:3]} : {1'b0, s[14:3]};
		e = seg_of(m, A_BASE);
		t = (e < 3'h2) ? 4'(m >> 1) : 4'(m >> e);
		return {~neg, e, t} ^ A_INV;
	endfunction

	// Companded byte back to a linear 16-bit sample
	function automatic logic [15:0] expand(input logic [7:0] b,
		input logic alaw);
		logic [7:0] u;
		logic [15:0] t;
		if (!alaw) begin
			u = b ^ MU_INV;
			t = {8'h00, {1'b0, u[3:0], 3'h0} + 8'h84};
			t = t << u[6:4];
			return u[7] ? 16'(16'h0084 - t) : 16'(t - 16'h0084);
		end
		u = b ^ A_INV;
		t = {8'h00, u[3:0], 4'h0};
		if (u[6:4] == 3'h0) begin
			t = t + 16'h0008;
		end else begin
			t = (t + 16'h0108) << (u[6:4] - 3'h1);
		end
		return u[7] ? t : 16'(-t);
	endfunction

endpackage

// file: audio_link_if.sv
// Serial audio link between the codec port and its controller
`timescale 1ns/1ps
`default_nettype none
interface audio_link_if;
	logic bclk_dev;
	logic bclk_dev_oe;
	logic bclk_host;
	logic bclk_host_oe;
	logic frame_dev;
	logic frame_dev_oe;
	logic frame_host;
	logic frame_host_oe;
	logic adc_data;
	logic dac_data;
	logic bclk;
	logic frame;

	// Wire levels from the enables; undriven pins rest low
	assign bclk = bclk_dev_oe ? bclk_dev : (bclk_host_oe & bclk_host);
	assign frame = frame_dev_oe ? frame_dev : (frame_host_oe & frame_host);

	modport dev (
		input bclk,
		input frame,
		input dac_data,
		output bclk_dev,
		output bclk_dev_oe,
		output frame_dev,
		output frame_dev_oe,
		output adc_data
	);

	modport host (
		input bclk,
		input frame,
		input adc_data,
		output bclk_host,
		output bclk_host_oe,
		output frame_host,
		output frame_host_oe,
		output dac_data
	);
endinterface
`default_nettype wire

// file: audio_port_host.sv
// Controller end: APB registers, optional clock master, byte exchange
`timescale 1ns/1ps
`default_nettype none
module audio_port_host
	import audio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	audio_link_if.host link
);
	logic [3:0] ctrl;
	logic [7:0] half;
	logic [10:0] rate;
	logic [7:0] txb;
	logic [7:0] rxb;
	logic fresh;
	logic [2:0] bsync;
	logic [1:0] fsync;
	logic [1:0] dsync;
	logic [7:0] hcnt;
	logic bclk_q;
	logic brise;
	logic bfall;
	logic [10:0] fcnt;
	logic frame_q;
	logic lvl_prev;
	word_state_t state;
	logic [7:0] sh;
	logic [2:0] tcnt;
	logic [2:0] rcnt;
	logic [6:0] rsh;
	logic rx_act;
	logic wr;
	logic rd;
	logic rise_evt;
	logic fall_evt;
	logic [10:0] next_fcnt;
	logic [10:0] per;
	logic next_frame;
	logic frame_now;
	logic start;
	logic load;
	logic rx_done;

	// Zero wait states: access phase completes at once
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr = psel & penable & pwrite & ce;
	assign rd = psel & penable & ~pwrite & ce;

	// Registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 4'h0;
			half <= H_HALF_RESET;
			rate <= FRATE_RESET;
			txb <= 8'h00;
		end else if (wr) begin
			unique case (paddr)
				H_CTRL: ctrl <= pwdata[3:0];
				H_HALF: half <= pwdata[7:0];
				H_RATE: rate <= pwdata[10:0];
				H_TX: txb <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			unique case (paddr)
				H_CTRL: prdata <= {28'h0, ctrl};
				H_HALF: prdata <= {24'h0, half};
				H_RATE: prdata <= {21'h0, rate};
				H_TX: prdata <= {24'h0, txb};
				H_RX: prdata <= {23'h0, fresh, rxb};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsync <= 3'h0;
			fsync <= 2'h0;
			dsync <= 2'h0;
		end else if (ce) begin
			bsync <= {bsync[1:0], link.bclk};
			fsync <= {fsync[0], link.frame};
			dsync <= {dsync[0], link.adc_data};
		end
	end

	// Bit clock: toggles every half count when mastering it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt <= 8'h00;
			bclk_q <= 1'b0;
			brise <= 1'b0;
			bfall <= 1'b0;
		end else if (ce) begin
			brise <= 1'b0;
			bfall <= 1'b0;
			if (!(ctrl[H_DRV_BCLK] && ctrl[H_RUN])) begin
				hcnt <= 8'h00;
				bclk_q <= 1'b0;
			end else if (hcnt + 8'h01 >= half) begin
				hcnt <= 8'h00;
				bclk_q <= ~bclk_q;
				brise <= ~bclk_q;
				bfall <= bclk_q;
			end else begin
				hcnt <= hcnt + 8'h01;
			end
		end
	end

	assign rise_evt = ctrl[H_DRV_BCLK] ? brise : (bsync[1] & ~bsync[2]);
	assign fall_evt = ctrl[H_DRV_BCLK] ? bfall : (~bsync[1] & bsync[2]);
	assign per = (rate < FRATE_MIN) ? FRATE_MIN : rate;
	assign next_fcnt = (fcnt >= per - 11'h001) ? 11'h000 : fcnt + 11'h001;
	assign next_frame = next_fcnt < (per >> 1);
	assign frame_now = ctrl[H_DRV_FRAME] ? next_frame : fsync[1];
	assign start = fall_evt & frame_now & ~lvl_prev;
	assign load = fall_evt &
		((start & ctrl[H_MODE_B]) | (state == WORD_ARMED));
	assign rx_done = rise_evt & rx_act & (rcnt == WORD_LAST);

	// Frame clock counted in bit clock falls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcnt <= 11'h7ff;
			frame_q <= 1'b0;
			lvl_prev <= 1'b0;
		end else if (ce) begin
			if (!(ctrl[H_DRV_FRAME] && ctrl[H_RUN])) begin
				fcnt <= 11'h7ff;
				frame_q <= 1'b0;
			end else if (fall_evt) begin
				fcnt <= next_fcnt;
				frame_q <= next_frame;
			end
			if (fall_evt) begin
				lvl_prev <= frame_now;
			end
		end
	end

	// Outgoing byte, MSB first, changed on falls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= WORD_IDLE;
			sh <= 8'h00;
			tcnt <= 3'h0;
		end else if (ce && fall_evt) begin
			if (load) begin
				state <= WORD_SHIFT;
				sh <= txb;
				tcnt <= 3'h0;
			end else if (start) begin
				state <= WORD_ARMED;
			end else if (state == WORD_SHIFT) begin
				sh <= {sh[6:0], 1'b0};
				tcnt <= tcnt + 3'h1;
				if (tcnt == WORD_LAST) begin
					state <= WORD_IDLE;
				end
			end
		end
	end

	// Incoming byte sampled on rises; new byte beats a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_act <= 1'b0;
			rcnt <= 3'h0;
			rsh <= 7'h00;
			rxb <= 8'h00;
			fresh <= 1'b0;
		end else if (ce) begin
			if (load) begin
				rx_act <= 1'b1;
				rcnt <= 3'h0;
			end else if (rise_evt && rx_act) begin
				rsh <= {rsh[5:0], dsync[1]};
				rcnt <= rcnt + 3'h1;
				rx_act <= (rcnt != WORD_LAST);
			end
			if (rx_done) begin
				rxb <= {rsh, dsync[1]};
				fresh <= 1'b1;
			end else if (rd && paddr == H_RX) begin
				fresh <= 1'b0;
			end
		end
	end

	assign link.bclk_host = bclk_q;
	assign link.bclk_host_oe = ctrl[H_DRV_BCLK];
	assign link.frame_host = frame_q;
	assign link.frame_host_oe = ctrl[H_DRV_FRAME];
	assign link.dac_data = sh[7];
endmodule
`default_nettype wire

// file: audio_port_device.sv
// Codec end: clock generation and direction, companding, 8-bit words
//
// Implementation choice: a plain write-strobe port to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Separate direction bits for bit and frame clocks
// - Master clocks run only with a channel enabled
// - Slave mode keeps clock drivers off
// - Each clock's direction set independently
// - Master clock input used when pin unselected
// - Bit clock divided from system clock when output
// - Divider code table, reset divide by eight
// - Frame clock derived from either bit clock
// - Frame rate is eleven-bit divisor, 8 to 2047
// - Even rates give equal high and low
// - Per-side companding enable and law type
// - Segment approximation of mu and A laws
// - Invert all bits mu, even bits A
// - Companded byte sent in top eight positions
// - Compress 13 or 12 bit magnitudes to 8
// - Sign, three-bit exponent, four-bit mantissa byte
// - Eight-bit words whenever either companding enabled
// - Mode B bytes back to back every eight
// - Enable bit clear selects linear 8-bit mode, type bit ignored
// - MSB at first rise mode B, second A
module audio_port_device
	import audio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic adc_active,
	input wire logic dac_active,
	input wire logic shared_pin_function,
	input wire logic mclk,
	input wire logic dsp_mode_b,
	input wire logic [15:0] tx_sample,
	output logic tx_load,
	output logic [15:0] rx_sample,
	output logic rx_valid,
	audio_link_if.dev link
);
	logic [3:0] compand;
	logic frame_dir;
	logic bit_dir;
	logic [4:0] bdiv_code;
	logic [10:0] frate;
	logic [2:0] bsync;
	logic [1:0] fsync;
	logic [1:0] dsync;
	logic [5:0] bcnt;
	logic [5:0] bper;
	logic bclk_q;
	logic brise;
	logic bfall;
	logic [10:0] fcnt;
	logic [10:0] fper;
	logic frame_q;
	logic lvl_prev;
	word_state_t state;
	logic [7:0] sh;
	logic [2:0] tcnt;
	logic [2:0] rcnt;
	logic [6:0] rsh;
	logic rx_act;
	logic run;
	logic b_src;
	logic rise_evt;
	logic fall_evt;
	logic [5:0] ratio;
	logic [5:0] next_bcnt;
	logic [10:0] rate_ok;
	logic [10:0] next_fcnt;
	logic next_frame;
	logic frame_now;
	logic start;
	logic load;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;

	// Control registers on the device's own port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compand <= 4'h0;
			frame_dir <= 1'b0;
			bit_dir <= 1'b0;
			bdiv_code <= BDIV_RESET;
			frate <= FRATE_RESET;
		end else if (ce && reg_wr) begin
			unique case (reg_addr)
				OFS_COMPAND: compand <= reg_wdata[3:0];
				OFS_DIR: begin
					frame_dir <= reg_wdata[FRAME_DIR_BIT];
					bit_dir <= reg_wdata[BIT_DIR_BIT];
				end
				OFS_BDIV: bdiv_code <= reg_wdata[4:0];
				OFS_FRATE: frate <= reg_wdata[10:0];
				default: ;
			endcase
		end
	end

	// Registered read-back; unmapped offsets read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_rdata <= 16'h0000;
		end else if (ce) begin
			unique case (reg_addr)
				OFS_COMPAND: reg_rdata <= {12'h000, compand};
				OFS_DIR: reg_rdata <= 16'((frame_dir << FRAME_DIR_BIT)
					| (bit_dir << BIT_DIR_BIT));
				OFS_BDIV: reg_rdata <= {11'h000, bdiv_code};
				OFS_FRATE: reg_rdata <= {5'h00, frate};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// Source picked before the synchroniser; a switch may cost one edge
	assign b_src = shared_pin_function ? link.bclk : mclk;

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsync <= 3'h0;
			fsync <= 2'h0;
			dsync <= 2'h0;
		end else if (ce) begin
			bsync <= {bsync[1:0], b_src};
			fsync <= {fsync[0], link.frame};
			dsync <= {dsync[0], link.dac_data};
		end
	end

	assign run = adc_active | dac_active;
	// Divide by one cannot leave a flop; it runs as divide by two
	assign ratio = (div_ratio(bdiv_code) < BDIV_MIN) ? BDIV_MIN
		: div_ratio(bdiv_code);
	assign next_bcnt = (bcnt >= bper - 6'h01) ? 6'h00 : bcnt + 6'h01;

	// Bit clock master: period reloaded only at wrap, so no runt pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt <= 6'h00;
			bper <= BDIV_DEFAULT;
			bclk_q <= 1'b0;
		end else if (ce) begin
			if (!(bit_dir && run)) begin
				bcnt <= 6'h00;
				bper <= ratio;
				bclk_q <= 1'b0;
			end else begin
				bcnt <= next_bcnt;
				if (next_bcnt == 6'h00) begin
					bper <= ratio;
				end
				bclk_q <= next_bcnt < (bper >> 1);
			end
		end
	end

	// Flagged a cycle early so frame and data move with the bit clock fall
	assign brise = bit_dir & run & (next_bcnt == 6'h00);
	assign bfall = bit_dir & run & (next_bcnt == (bper >> 1));

	// Edges from own bit clock or the synchronised one
	assign rise_evt = bit_dir ? brise : (bsync[1] & ~bsync[2]);
	assign fall_evt = bit_dir ? bfall : (~bsync[1] & bsync[2]);
	assign rate_ok = (frate < FRATE_MIN) ? FRATE_MIN : frate;
	assign next_fcnt = (fcnt >= fper - 11'h001) ? 11'h000 : fcnt + 11'h001;
	assign next_frame = next_fcnt < (fper >> 1);

	// Frame master counts bit clock falls, rate reloaded at wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcnt <= 11'h7ff;
			fper <= FRATE_RESET;
			frame_q <= 1'b0;
		end else if (ce) begin
			if (!(frame_dir && run)) begin
				fcnt <= 11'h7ff;
				fper <= rate_ok;
				frame_q <= 1'b0;
			end else if (fall_evt) begin
				fcnt <= next_fcnt;
				if (next_fcnt == 11'h000) begin
					fper <= rate_ok;
				end
				frame_q <= next_frame;
			end
		end
	end

	// Frame level as seen at each fall, master or slave
	assign frame_now = frame_dir ? next_frame : fsync[1];
	assign start = fall_evt & frame_now & ~lvl_prev;
	assign load = fall_evt & ((start & dsp_mode_b) | (state == WORD_ARMED));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_prev <= 1'b0;
		end else if (ce && fall_evt) begin
			lvl_prev <= frame_now;
		end
	end

	// Compressed when enabled, else plain top byte of the sample
	always_comb begin
		if (compand[TX_EN_BIT]) begin
			tx_byte = compress(tx_sample, compand[TX_TYPE_BIT]);
		end else begin
			tx_byte = tx_sample[15:8];
		end
	end

	// Transmit shifter: eight bits MSB first, zeros after them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= WORD_IDLE;
			sh <= 8'h00;
			tcnt <= 3'h0;
			tx_load <= 1'b0;
		end else if (ce) begin
			tx_load <= load;
			if (load) begin
				state <= WORD_SHIFT;
				sh <= tx_byte;
				tcnt <= 3'h0;
			end else if (start) begin
				state <= WORD_ARMED;
			end else if (fall_evt && state == WORD_SHIFT) begin
				sh <= {sh[6:0], 1'b0};
				tcnt <= tcnt + 3'h1;
				if (tcnt == WORD_LAST) begin
					state <= WORD_IDLE;
				end
			end
		end
	end

	assign rx_byte = {rsh, dsync[1]};

	// Receive shifter: eight rises after each load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_act <= 1'b0;
			rcnt <= 3'h0;
			rsh <= 7'h00;
			rx_sample <= 16'h0000;
			rx_valid <= 1'b0;
		end else if (ce) begin
			rx_valid <= 1'b0;
			if (load) begin
				rx_act <= 1'b1;
				rcnt <= 3'h0;
			end else if (rise_evt && rx_act) begin
				rsh <= {rsh[5:0], dsync[1]};
				rcnt <= rcnt + 3'h1;
				if (rcnt == WORD_LAST) begin
					rx_act <= 1'b0;
					rx_valid <= 1'b1;
					if (compand[RX_EN_BIT]) begin
						rx_sample <= expand(rx_byte, compand[RX_TYPE_BIT]);
					end else begin
						rx_sample <= {rx_byte, 8'h00};
					end
				end
			end
		end
	end

	// Drivers enabled only by the direction bits
	assign link.bclk_dev = bclk_q;
	assign link.bclk_dev_oe = bit_dir;
	assign link.frame_dev = frame_q;
	assign link.frame_dev_oe = frame_dir;
	assign link.adc_data = sh[7];
endmodule
`default_nettype wire

// file: audio_port_host_note_end.sv
// Empty unit: holds no code of its own
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: audio_link_sva.sv
// Link checker for the serial audio port, fed with the link's signals
`timescale 1ns/1ps
`default_nettype none
module audio_link_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bclk_dev,
	input wire logic bclk_dev_oe,
	input wire logic bclk_host_oe,
	input wire logic frame_dev,
	input wire logic frame_dev_oe,
	input wire logic adc_data,
	input wire logic dac_data,
	input wire logic bclk
);
	logic bclk_q;
	logic frame_q;
	logic started;
	logic [11:0] per_cnt;
	logic [11:0] hi_cnt;
	wire logic rise = bclk & ~bclk_q;
	wire logic any_oe = bclk_dev_oe | bclk_host_oe;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Delayed copies for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_q <= 1'b0;
			frame_q <= 1'b0;
		end else begin
			bclk_q <= bclk;
			frame_q <= frame_dev;
		end
	end

	// Bit clock rises per frame; restart when a clock source drops away
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt <= 12'h000;
			hi_cnt <= 12'h000;
			started <= 1'b0;
		end else if (!frame_dev_oe || !any_oe) begin
			per_cnt <= 12'h000;
			hi_cnt <= 12'h000;
			started <= 1'b0;
		end else if (frame_dev && !frame_q) begin
			per_cnt <= 12'h000;
			hi_cnt <= 12'h000;
			started <= 1'b1;
		end else if (rise) begin
			per_cnt <= per_cnt + 12'h001;
			hi_cnt <= hi_cnt + 12'(frame_dev);
		end
	end

	sequence frame_start;
		$rose(frame_dev) ##0 frame_dev_oe;
	endsequence

	sequence frame_end;
		$fell(frame_dev) ##0 (frame_dev_oe && started);
	endsequence

	a_frame_period_min: assert property (frame_start |-> !started || per_cnt >= 12'h008)
		else $error("frame shorter than eight bit clocks");
	a_frame_high_min: assert property (frame_end |-> hi_cnt >= 12'h004)
		else $error("frame high phase too short");
	a_frame_on_low: assert property (frame_start |-> !bclk)
		else $error("frame rose while bit clock high");
	a_adc_on_fall: assert property ($changed(adc_data) |-> !bclk)
		else $error("transmit data moved while bit clock high");
	a_dac_on_fall: assert property ($changed(dac_data) |-> !bclk)
		else $error("receive data moved while bit clock high");
	a_bclk_quiet_off: assert property (!bclk_dev_oe && !$past(bclk_dev_oe) |-> !bclk_dev)
		else $error("bit clock driver active while off");
	a_frame_quiet_off: assert property (!frame_dev_oe [*2] |-> !frame_dev)
		else $error("frame driver active while off");
	a_bclk_high_bound: assert property ($rose(bclk_dev) |-> ##[1:24] !bclk_dev)
		else $error("bit clock high beyond largest half period");
endmodule
`default_nettype wire

// file: audio_port_clocking_compander_tb_top.sv
// Bench: codec end and controller end joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module audio_port_clocking_compander_tb_top;
	import audio_pkg::*;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, reg_wr = 0, tx_load, rx_valid;
	logic [7:0] reg_addr = '0, ct, eb, hb;
	logic [15:0] reg_wdata = '0, reg_rdata, tx_sample = '0, rx_sample, sm, es;
	logic adc_active = 0, dac_active = 0, spf = 0, mclk = 0, mode_b = 1;
	logic [2:0] mc = '0;
	logic [55:0] c;
	int miscompares = 0, samples_checked = 0, per, hi, n, r;
	// Control byte, sample, byte seen, byte sent, sample expected
	localparam logic [55:0] DT [6] = '{56'h0a_0000_ff_80_7d7c,
		56'h0a_8000_00_ff_0000, 56'h0a_7fff_80_00_8284,
		56'h0f_7fff_aa_d5_0008, 56'h0f_0000_d5_aa_7e00,
		56'h0f_ffff_55_55_fff8};

	audio_link_if link ();
	audio_port_device audio_port_device_inst (.pclk(pclk), .presetn(presetn),
		.ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .adc_active(adc_active),
		.dac_active(dac_active), .shared_pin_function(spf), .mclk(mclk),
		.dsp_mode_b(mode_b), .tx_sample(tx_sample), .tx_load(tx_load),
		.rx_sample(rx_sample), .rx_valid(rx_valid), .link(link.dev));
	audio_port_host audio_port_host_inst (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.host));
	audio_link_sva chk_inst (.pclk(pclk), .presetn(presetn),
		.bclk_dev(link.bclk_dev), .bclk_dev_oe(link.bclk_dev_oe),
		.bclk_host_oe(link.bclk_host_oe), .frame_dev(link.frame_dev),
		.frame_dev_oe(link.frame_dev_oe), .adc_data(link.adc_data),
		.dac_data(link.dac_data), .bclk(link.bclk));

	// 200 MHz system clock
	always #2.5 pclk = ~pclk;

	// Master clock of twelve pclk periods, edges kept on pclk for repeatability
	always @(posedge pclk) begin
		mc <= (mc == 3'd5) ? 3'd0 : mc + 3'd1;
		if (mc == 3'd5) mclk <= ~mclk;
	end

	// Divider code to ratio; code 0 runs at two, reserved codes at eight
	function automatic int ediv(input int code);
		int t[21] = '{2, 8, 2, 3, 4, 5, 8, 6, 8, 10, 8, 12, 16, 20, 22, 24, 8,
			30, 32, 44, 48};
		return t[code];
	endfunction

	task automatic chk(input string s, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	// One APB transfer; read data lands in q
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		chk("pslverr", 0, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic dwr(input logic [7:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge pclk);
		reg_wr <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic drd(input logic [7:0] a, input logic [15:0] e);
		reg_addr <= a;
		repeat (2) @(posedge pclk);
		chk("reg_rdata", e, reg_rdata);
	endtask

	// Pclk cycles from one rise of the wire to the next, and high samples
	task automatic meas(input bit f);
		logic p;
		logic v;
		p = 1'b1;
		v = 1'b1;
		per = 0;
		hi = 0;
		n = 0;
		while (!(v && !p) && n < 9000) begin
			p = v;
			@(posedge pclk);
			v = f ? link.frame : link.bclk;
			n++;
		end
		do begin
			p = v;
			@(posedge pclk);
			v = f ? link.frame : link.bclk;
			per++;
			hi += v;
		end while (!(v && !p) && per < 9000);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Cut a hang short; the tests need well under this span
	initial begin
		repeat (90000) @(posedge pclk);
		miscompares++;
		complete_run();
	end

	initial begin
		void'($urandom(97284));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		drd(OFS_COMPAND, 16'h0000);
		drd(OFS_DIR, 16'h0000);
		drd(OFS_BDIV, 16'h0008);
		drd(OFS_FRATE, 16'h0022);
		chk("oe", 0, {link.frame_dev_oe, link.bclk_dev_oe});
		apb(0, H_RATE, 0);
		chk("host rate", 32'h22, q);
		apb(0, 12'h0f0, 0);
		chk("unmapped", 0, q);
		tdone("reset");
		// Every combination of the two direction bits, no channel enabled yet
		for (int d = 0; d < 4; d++) begin
			dwr(OFS_DIR, 16'({d[1], 2'b00, d[0], 6'h00}));
			chk("dir oe", d[1:0], {link.frame_dev_oe, link.bclk_dev_oe});
		end
		dwr(OFS_BDIV, 16'h0002);
		n = 0;
		repeat (200) begin
			@(posedge pclk);
			n += link.bclk | link.frame;
		end
		chk("idle clocks", 0, n);
		{adc_active, dac_active} <= 2'b01 << $urandom_range(1);
		tdone("direction");
		// Divider codes 0 to 20, reserved ones among them included
		for (int k = 0; k < 21; k++) begin
			dwr(OFS_BDIV, 16'(k));
			meas(0);
			meas(0);
			chk("bclk period", ediv(k), per);
			chk("bclk high", ediv(k) / 2, hi);
		end
		// Freeze in a low phase of divide by 48; a half period must not move
		while (link.bclk !== 1'b1) @(posedge pclk);
		while (link.bclk !== 1'b0) @(posedge pclk);
		ce <= 1'b0;
		repeat (2) @(posedge pclk);
		r = link.bclk;
		repeat (24) @(posedge pclk);
		chk("frozen bclk", r, link.bclk);
		ce <= 1'b1;
		tdone("divider");
		dwr(OFS_BDIV, 16'h0002);
		for (int k = 0; k < 6; k++) begin
			r = (k == 0) ? 7 : (k == 1) ? 8 : (k == 2) ? 9 : (k == 3) ? 2047 :
				$urandom_range(60, 10);
			dwr(OFS_FRATE, 16'(r));
			r = (r < 8) ? 8 : r;
			meas(1);
			meas(1);
			chk("frame period", r * 2, per);
			chk("frame high", (r / 2) * 2, hi);
		end
		tdone("frame rate");
		// Bit clock from master clock input, then from the controller
		dwr(OFS_FRATE, 16'h0008);
		dwr(OFS_DIR, 16'h0200);
		r = $urandom_range(20);
		dwr(OFS_BDIV, 16'(r));
		meas(1);
		meas(1);
		chk("mclk frame", 96, per);
		spf <= 1'b1;
		apb(1, H_HALF, 5);
		apb(1, H_CTRL, 32'h9);
		meas(1);
		meas(1);
		chk("ext frame", 80, per);
		// Now the reverse: device bit clock, controller frame
		dwr(OFS_DIR, 16'h0040);
		apb(1, H_RATE, 8);
		apb(1, H_CTRL, 32'ha);
		meas(1);
		meas(1);
		chk("host frame", 8 * ediv(r), per);
		tdone("mixed");
		dwr(OFS_DIR, 16'h0000);
		apb(1, H_CTRL, 32'hc);
		dwr(OFS_BDIV, 16'h000c);
		dwr(OFS_DIR, 16'h0240);
		for (int i = 0; i < 11; i++) begin
			c = (i < 6) ? DT[i] : {8'h05, 16'($urandom), 32'h0};
			{ct, sm, eb, hb, es} = c;
			if (i >= 6) begin
				hb = 8'($urandom);
				eb = sm[15:8];
				es = {hb, 8'h00};
			end
			if (i == 9) begin
				mode_b <= 1'b0;
				apb(1, H_CTRL, 32'h8);
				dwr(OFS_FRATE, 16'h0010);
			end
			dwr(OFS_COMPAND, {8'h00, ct});
			tx_sample <= sm;
			apb(1, H_TX, {24'h0, hb});
			repeat (3) begin
				n = 0;
				do begin
					@(posedge pclk);
					n++;
				end while (rx_valid !== 1'b1 && n < 3000);
				chk("rx_valid", 1, rx_valid);
			end
			chk("rx_sample", es, rx_sample);
			apb(0, H_RX, 0);
			chk("tx byte", eb, q[7:0]);
			chk("rx fresh", 1, q[8]);
		end
		tdone("data");
		complete_run();
	end
endmodule
`default_nettype wire
